// *** verilog/adapter_regs_pkg.sv ***
package adapter_regs_pkg;

    // register addresses on the serial register port
    localparam logic [7:0] ADDR_TRIM_SIG   = 8'h13;
    localparam logic [7:0] ADDR_HANDSHAKE  = 8'h16;
    localparam logic [7:0] ADDR_OUT_FUNC   = 8'h19;
    localparam logic [7:0] ADDR_SHAPE_DATA = 8'h1c;

    // baseband handshake register fields
    localparam int BIT_BB_READY = 2;

    // output function register fields
    localparam int BIT_MOD_FLOAT = 7;
    localparam int BIT_SHAPE_RST = 6;
    localparam int BIT_AMP_FLOAT = 5;
    localparam int BIT_CLK_EN    = 4;
    localparam int TEST_LSB      = 1;
    localparam int TEST_W        = 3;

    // crystal trim field
    localparam int TRIM_W = 7;

    // reset values
    localparam logic [7:0] RST_HANDSHAKE = 8'h00;
    localparam logic [7:0] RST_OUT_FUNC  = 8'h00;
    localparam logic [7:0] RST_TRIM      = 8'h00;

    // writable bits; everything else is stored as zero
    localparam logic [7:0] MASK_HANDSHAKE = 8'h04;
    localparam logic [7:0] MASK_OUT_FUNC  = 8'hbe;
    localparam logic [7:0] MASK_TRIM      = 8'h7f;

    // modulation shaping table
    localparam int SHAPE_DEPTH = 13;
    localparam int SHAPE_IDX_W = 4;
    localparam logic [SHAPE_IDX_W-1:0] SHAPE_LAST = 4'hc;
    localparam logic [7:0] SHAPE_RST [SHAPE_DEPTH] = '{
        8'h37, 8'h38, 8'h3a, 8'h3e, 8'h47, 8'h54, 8'h64,
        8'h74, 8'h81, 8'h89, 8'h8e, 8'h90, 8'h91
    };

    // switch clock synthesis, frequencies in kHz
    localparam int SYS_CLK_KHZ = 10000;
    localparam int SW_CLK_KHZ  = 2048;
    localparam int NCO_GCD     = 16;
    localparam int NCO_W       = 10;
    localparam logic [NCO_W-1:0] NCO_STEP = NCO_W'(SW_CLK_KHZ / NCO_GCD);
    localparam logic [NCO_W-1:0] NCO_MOD  = NCO_W'(SYS_CLK_KHZ / NCO_GCD);
    localparam logic [NCO_W-1:0] NCO_HALF = NCO_W'((SYS_CLK_KHZ / NCO_GCD + 1) / 2);

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } reg_rsp_t;

endpackage

// *** verilog/switch_clock_gen.sv ***
`timescale 1ns/1ps
module switch_clock_gen
    import adapter_regs_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // control
    input  wire logic run,
    // clock out
    output logic      clk_out
);

    logic [NCO_W-1:0] phase;
    logic [NCO_W:0]   next_sum;

    // fractional divider: average rate is exact, edges jitter by one sys_clk
    always_comb begin
        next_sum = {1'b0, phase} + {1'b0, NCO_STEP};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !run) begin
            phase <= '0;
        end else if (next_sum >= {1'b0, NCO_MOD}) begin
            phase <= NCO_W'(next_sum - {1'b0, NCO_MOD});
        end else begin
            phase <= next_sum[NCO_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !run) begin
            clk_out <= 1'b0;
        end else begin
            clk_out <= (phase >= NCO_HALF);
        end
    end

endmodule

// *** verilog/adapter_control_registers.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) ready bit at 22 bit2 drives clock request
// (RL2) controller leaves reserved handshake bits alone
// (RL3) modulation output grounded or floats outside transmit
// (RL4) writing one to bit6 rewinds shaping pointer
// (RL5) amplifier output grounded or floats outside transmit
// (RL6) bit4 puts 2.048 MHz on switch pin
// (RL7) test bits are not for normal use
// (RL8) trim register at 19 sets crystal load
// (RL9) trim bits give binary weighted capacitance
// (RL10) read-only signature at 19, writes ignored
// (RL11) after rewind, writes fill entries upward from zero
// (RL12) pointer sticks on last entry, no wrap
// (RL13) address 19 writes trim, reads signature
module adapter_control_registers
    import adapter_regs_pkg::*;
#(
    // arbitrary value, not a real part code
    parameter logic [7:0] CHIPSET_SIGNATURE = 8'h5a
)
(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    // register port from the serial interface
    input  wire reg_req_t               reg_req,
    output reg_rsp_t                    reg_rsp,
    // packet and datapath inputs
    input  wire logic                   tx_packet,
    input  wire logic [SHAPE_IDX_W-1:0] shape_sel,
    input  wire logic [7:0]             amp_level,
    input  wire logic                   tx_switch_in,
    input  wire logic                   clk_need,
    // system clock request
    output logic                        sys_clk_req,
    // modulation output
    output logic [7:0]                  mod_out,
    output logic                        mod_oe,
    // power amplifier control output
    output logic [7:0]                  amp_out,
    output logic                        amp_oe,
    // transmit switch pin
    output logic                        tx_switch_pin,
    // crystal load and test controls
    output logic [TRIM_W-1:0]           crystal_load_trim,
    output logic [TEST_W-1:0]           test_ctrl
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0]             baseband_handshake_reg;
    logic [7:0]             output_function_reg;
    logic [7:0]             crystal_load_trim_reg;
    logic [7:0]             shape_table [SHAPE_DEPTH];
    logic [SHAPE_IDX_W-1:0] shape_ptr;
    logic                   sw_clk;

    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            baseband_handshake_reg <= RST_HANDSHAKE;
        end else if (hit(reg_req, ADDR_HANDSHAKE)) begin
            // reserved bits are never stored
            baseband_handshake_reg <= reg_req.wdata & MASK_HANDSHAKE; // [RL1] [RL2]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            output_function_reg <= RST_OUT_FUNC;
        end else if (hit(reg_req, ADDR_OUT_FUNC)) begin
            // rewind bit is a strobe, so it is masked out of storage
            output_function_reg <= reg_req.wdata & MASK_OUT_FUNC;
        end
    end

    // writes at the shared address land in trim; signature has no storage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            crystal_load_trim_reg <= RST_TRIM;
        end else if (hit(reg_req, ADDR_TRIM_SIG)) begin
            crystal_load_trim_reg <= reg_req.wdata & MASK_TRIM; // [RL8] [RL13] [RL10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shaping table and its write pointer

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shape_ptr <= '0;
        end else if (hit(reg_req, ADDR_OUT_FUNC) && reg_req.wdata[BIT_SHAPE_RST]) begin
            shape_ptr <= '0; // [RL4] [RL11]
        end else if (hit(reg_req, ADDR_SHAPE_DATA) && (shape_ptr != SHAPE_LAST)) begin
            shape_ptr <= shape_ptr + 4'h1; // [RL11] [RL12]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < SHAPE_DEPTH; gi++) begin : g_shape
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    shape_table[gi] <= SHAPE_RST[gi];
                end else if (hit(reg_req, ADDR_SHAPE_DATA) && (shape_ptr == SHAPE_IDX_W'(gi))) begin
                    // saturated pointer keeps hitting the last entry
                    shape_table[gi] <= reg_req.wdata; // [RL11] [RL12]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read path: one cycle after the read strobe

    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_req.addr == ADDR_TRIM_SIG) begin
            next_rdata = CHIPSET_SIGNATURE; // [RL10] [RL13]
        end else if (reg_req.addr == ADDR_HANDSHAKE) begin
            next_rdata = baseband_handshake_reg;
        end else if (reg_req.addr == ADDR_OUT_FUNC) begin
            next_rdata = output_function_reg;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.rd;
            reg_rsp.rdata <= reg_req.rd ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin functions

    switch_clock_gen u_switch_clock_gen (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .run     (output_function_reg[BIT_CLK_EN]),
        .clk_out (sw_clk)
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sys_clk_req <= 1'b0;
        end else begin
            // ready keeps the system clock requested even when idle
            sys_clk_req <= baseband_handshake_reg[BIT_BB_READY] | clk_need; // [RL1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_switch_pin <= 1'b0;
        end else begin
            tx_switch_pin <= output_function_reg[BIT_CLK_EN] ? sw_clk : tx_switch_in; // [RL6]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mod_out <= 8'h00;
            mod_oe  <= 1'b1;
        end else if (tx_packet) begin
            // out-of-range selects clamp to the last entry
            mod_out <= shape_table[(shape_sel > SHAPE_LAST) ? SHAPE_LAST : shape_sel];
            mod_oe  <= 1'b1;
        end else begin
            mod_out <= 8'h00;
            mod_oe  <= ~output_function_reg[BIT_MOD_FLOAT]; // [RL3]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            amp_out <= 8'h00;
            amp_oe  <= 1'b1;
        end else if (tx_packet) begin
            amp_out <= amp_level;
            amp_oe  <= 1'b1;
        end else begin
            amp_out <= 8'h00;
            amp_oe  <= ~output_function_reg[BIT_AMP_FLOAT]; // [RL5]
        end
    end

    // each trim bit is one binary-weighted capacitor switch
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            crystal_load_trim <= '0;
            test_ctrl         <= '0;
        end else begin
            crystal_load_trim <= crystal_load_trim_reg[TRIM_W-1:0]; // [RL9]
            test_ctrl         <= output_function_reg[TEST_LSB +: TEST_W]; // [RL7]
        end
    end

endmodule

// *** verif/bb_ctrl_model.sv ***
`timescale 1ns/1ps
module bb_ctrl_model
    import adapter_regs_pkg::*;
(
    // clock
    input  wire logic sys_clk,
    // register port
    output reg_req_t  reg_req
);
    initial reg_req = '0;
    task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == ADDR_HANDSHAKE) ? (d & 8'h04) : d;
        if (a == ADDR_OUT_FUNC) v = v & 8'hf0;
        @(negedge sys_clk);
        reg_req <= '{wr: w, rd: r, addr: a, wdata: v};
        @(negedge sys_clk);
        // released lines show the inverse, not the last value
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask
endmodule

// *** verif/adapter_control_registers_properties.sv ***
`timescale 1ns/1ps
module adapter_checks
    import adapter_regs_pkg::*;
#(
    parameter logic [7:0] CHIPSET_SIGNATURE = 8'h5a
)
(
    input wire logic             sys_clk,
    input wire logic             sys_rst,
    input wire reg_req_t         reg_req,
    input wire reg_rsp_t         reg_rsp,
    input wire logic             tx_packet,
    input wire logic             tx_switch_in,
    input wire logic             clk_need,
    input wire logic             sys_clk_req,
    input wire logic [7:0]       mod_out,
    input wire logic             mod_oe,
    input wire logic             amp_oe,
    input wire logic             tx_switch_pin,
    input wire logic [TRIM_W-1:0] crystal_load_trim
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_w(a);
        reg_req.wr && reg_req.addr == a;
    endsequence
    sequence s_fw;
        s_w(ADDR_OUT_FUNC) ##1 !reg_req.wr && !tx_packet;
    endsequence
    AST_RD_LAT: assert property (reg_req.rd |=> reg_rsp.valid) else $error("read not answered");
    AST_SIG: assert property (reg_req.rd && reg_req.addr == ADDR_TRIM_SIG
        |=> reg_rsp.rdata == CHIPSET_SIGNATURE) else $error("signature wrong");
    AST_HS: assert property (reg_req.rd && reg_req.addr == ADDR_HANDSHAKE
        |=> (reg_rsp.rdata & ~MASK_HANDSHAKE) == 8'h00) else $error("handshake reserved set");
    AST_TRIM: assert property (s_w(ADDR_TRIM_SIG) ##1 !reg_req.wr
        |=> crystal_load_trim == $past(reg_req.wdata[TRIM_W-1:0], 2)) else $error("trim wrong");
    AST_MOD: assert property (s_fw |=> mod_oe == !$past(reg_req.wdata[7], 2) && mod_out == 8'h00)
        else $error("mod float wrong");
    AST_AMP: assert property (s_fw |=> amp_oe == !$past(reg_req.wdata[5], 2)) else $error("amp float wrong");
    AST_SW_ON: assert property (s_w(ADDR_OUT_FUNC) ##0 reg_req.wdata[4] ##1 !reg_req.wr
        |-> ##[1:8] tx_switch_pin) else $error("switch clock absent");
    AST_SW_OFF: assert property (s_w(ADDR_OUT_FUNC) ##0 !reg_req.wdata[4] ##1 !reg_req.wr
        |=> tx_switch_pin == $past(tx_switch_in)) else $error("switch not passed");
    AST_REQ_NEED: assert property (clk_need |=> sys_clk_req) else $error("request missing");
    AST_REQ_RDY: assert property (s_w(ADDR_HANDSHAKE) ##0 reg_req.wdata[2] ##1 !reg_req.wr
        |=> sys_clk_req) else $error("ready ignored");
    AST_REQ_OFF: assert property (s_w(ADDR_HANDSHAKE) ##0 !reg_req.wdata[2] ##1 !reg_req.wr && !clk_need
        |=> !sys_clk_req) else $error("request stuck");
endmodule
bind adapter_control_registers adapter_checks #(.CHIPSET_SIGNATURE(CHIPSET_SIGNATURE)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rsp(reg_rsp), .tx_packet(tx_packet),
    .tx_switch_in(tx_switch_in), .clk_need(clk_need), .sys_clk_req(sys_clk_req), .mod_out(mod_out),
    .mod_oe(mod_oe), .amp_oe(amp_oe), .tx_switch_pin(tx_switch_pin), .crystal_load_trim(crystal_load_trim));

// *** verif/test_adapter_control_registers.sv ***
`timescale 1ns/1ps
module test_adapter_control_registers
    import adapter_regs_pkg::*;
;
    // arbitrary value
    localparam logic [7:0] SIG = 8'hc3;
    logic       sys_clk = 1'b0, sys_rst = 1'b1, tx_packet = 1'b0, tx_switch_in = 1'b0, clk_need = 1'b0;
    logic       sys_clk_req, mod_oe, amp_oe, tx_switch_pin, prev;
    logic [3:0] shape_sel = 4'h0;
    logic [7:0] amp_level = 8'h00, mod_out, amp_out, q[$];
    logic [7:0] fv [6] = '{8'h00, 8'h80, 8'h20, 8'ha0, 8'h40, 8'h10};
    logic [6:0] trim;
    logic [2:0] tst;
    logic [31:0] seed = 32'h21f9f9aa, r;
    reg_req_t   reg_req;
    reg_rsp_t   reg_rsp;
    int         n_fail = 0, check_count = 0, cyc = 0, ed;
    always #50 sys_clk = ~sys_clk;
    bb_ctrl_model bb (.sys_clk(sys_clk), .reg_req(reg_req));
    adapter_control_registers #(.CHIPSET_SIGNATURE(SIG)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rsp(reg_rsp), .tx_packet(tx_packet), .shape_sel(shape_sel),
        .amp_level(amp_level), .tx_switch_in(tx_switch_in), .clk_need(clk_need), .sys_clk_req(sys_clk_req),
        .mod_out(mod_out), .mod_oe(mod_oe), .amp_out(amp_out), .amp_oe(amp_oe), .tx_switch_pin(tx_switch_pin),
        .crystal_load_trim(trim), .test_ctrl(tst));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input string nm, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        bb.put(1'b1, 1'b0, a, d);
        repeat (2) @(negedge sys_clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        bb.put(1'b0, 1'b1, a, 8'h00);
        @(negedge sys_clk);
    endtask
    task pins(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    always @(negedge sys_clk) begin
        if (reg_rsp.valid === 1'b1) begin
            if (q.size() == 0) check("spare", 16'h1, 16'h0);
            else check("rdata", reg_rsp.rdata, q.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 9000) begin
            n_fail++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst <= 1'b0;
        pins(1);
        check("oe", {mod_oe, amp_oe, sys_clk_req}, 16'h6);
        rd(ADDR_HANDSHAKE, 8'h00);
        rd(8'h05, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_TRIM_SIG, (8'h01 << i) | 8'h80);
            check("trim", trim, 16'h1 << i);
            rd(ADDR_TRIM_SIG, SIG);
        end
        $display("trim test done");
        wr(ADDR_HANDSHAKE, 8'hff);
        check("req", sys_clk_req, 16'h1);
        rd(ADDR_HANDSHAKE, 8'h04);
        wr(ADDR_HANDSHAKE, 8'h00);
        check("req", sys_clk_req, 16'h0);
        clk_need <= 1'b1;
        pins(2);
        check("req", sys_clk_req, 16'h1);
        clk_need <= 1'b0;
        $display("handshake test done");
        foreach (fv[i]) begin
            wr(ADDR_OUT_FUNC, fv[i]);
            check("float", {mod_oe, amp_oe, mod_out}, {~fv[i][7], ~fv[i][5], 8'h00});
            check("amp_idle", amp_out, 16'h0);
            check("test_bits", tst, 16'h0);
            rd(ADDR_OUT_FUNC, fv[i] & MASK_OUT_FUNC);
        end
        prev = tx_switch_pin;
        ed = 0;
        repeat (625) begin
            @(negedge sys_clk);
            if (tx_switch_pin && !prev) ed++;
            prev = tx_switch_pin;
        end
        check("sw_edges", 16'(ed), 16'd128);
        wr(ADDR_OUT_FUNC, 8'h00);
        repeat (8) begin
            r = rnd();
            tx_switch_in <= r[0];
            pins(1);
            check("sw_pin", tx_switch_pin, tx_switch_in);
        end
        $display("output test done");
        r = rnd();
        tx_packet <= 1'b1;
        amp_level <= r[7:0];
        pins(2);
        check("pkt", {mod_oe, amp_oe, mod_out, amp_out}, {2'b11, 8'h37, r[7:0]});
        tx_packet <= 1'b0;
        wr(ADDR_SHAPE_DATA, 8'hee);
        wr(ADDR_SHAPE_DATA, 8'hee);
        wr(ADDR_OUT_FUNC, 8'h40);
        for (int i = 0; i < 14; i++) wr(ADDR_SHAPE_DATA, 8'h10 + 8'(i));
        tx_packet <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            shape_sel <= 4'(i);
            pins(2);
            check("shape", mod_out, (i > 11) ? 16'h1d : 16'h10 + 16'(i));
        end
        $display("shaping test done");
        check("pending", 16'(q.size()), 16'h0);
        complete_run();
    end
endmodule
